// ---- logic/snsol_top.sv ----
// serial nand status flags, otp control and feature link slave
//
// Overview of operation
// - 8-bit status read via 0FH at C0h
// - program fail set on failure or protected target, but otp mode programs ignore array failure
// - program fail cleared at execute or reset
// - erase fail set on failure or locked region
// - erase fail cleared at erase start, reset
// - write enable command sets the latch
// - write disable command clears the latch
// - busy flag high during listed operations
// - two-bit ecc result code encoding
// - ecc code cleared at reset, read start
// - eight otp pages programmed in order
// - set-features B0h enables otp access
// - otp protect bit starts at zero
// - otp programming only with access enabled
// - protect plus execute locks otp permanently
// - locked otp rejects further programming
// - locked at power-on means read only
// - erased cache, bad marker at byte 2048
// - internal ecc enable starts cleared
// - no write latch means program execute or block erase ignored
`timescale 1ns/1ps
`default_nettype none
module snsol_top (
	input wire logic SYS_CLK_I, // system clock
	input wire logic SYS_RST_I, // async reset, high
	input wire logic SCK_I, // link clock from host
	input wire logic CS_N_I, // chip select, low
	input wire logic SI_I, // serial data in
	output logic SO_O, // serial data out
	output logic SO_OE_O, // serial out enable
	input wire logic ARR_FAIL_I, // array op failed
	input wire logic ARR_LOCKED_I, // target locked
	input wire logic [1:0] ARR_ECC_I, // array ecc result
	input wire logic ARR_BAD_BLK_I, // read block is bad
	input wire logic OTP_LOCK_STRAP_I, // stored otp lock
	output logic [7:0] STATUS_O, // status byte copy
	output logic [7:0] OTP_REG_O // otp feature byte copy
);
	import snsol_pkg::*;

	// ==========================================================
	// helper functions
	// bits an opcode needs before it is passed on, zero if none
	function automatic logic [5:0] ev_len(input logic [7:0] op);
		case (op)
			OPC_WR_EN, OPC_WR_DIS, OPC_RESET,
			OPC_GLOCK, OPC_GUNLOCK: ev_len = LEN_CMD;
			OPC_SET: ev_len = LEN_SET;
			OPC_PROG_EXEC, OPC_PAGE_READ, OPC_ERASE,
			OPC_BLOCK, OPC_BUNLOCK: ev_len = LEN_ROW;
			default: ev_len = 6'h00;
		endcase
	endfunction : ev_len

	// feature byte seen at a feature address
	function automatic logic [7:0] feat(input logic [7:0] fa,
		input snsol_view_t v);
		case (fa)
			FA_STATUS: feat = v.status;
			FA_OTP: feat = v.otp;
			default: feat = 8'h00;
		endcase
	endfunction : feat

	// ==========================================================
	// link domain: frame shifter
	logic lrst; // frame reset, outside frames
	logic [5:0] cnt_q; // bits taken this frame
	logic [23:0] sh_q; // input shift register
	logic [7:0] cmd_q; // opcode of frame
	logic [7:0] fa_q; // feature address of get
	logic [11:0] col_q; // cache column
	logic [7:0] out_sh_q; // output shift register
	logic [2:0] dph_q; // bit within output byte
	logic in_data_q; // output phase active
	logic [23:0] bit_in; // shifter with new bit
	logic [7:0] cur_op; // opcode valid from bit 8
	logic [5:0] cur_len; // event length of opcode
	logic fire_l; // frame complete for event
	logic load_get; // load feature byte
	logic load_rd; // load cache byte
	logic reload; // next byte of data phase
	snsol_view_t view_s1_q; // view sync stage one
	snsol_view_t view_s2_q; // view sync stage two
	logic cache_bad_q; // cache holds bad block page
	snsol_cmd_t ev_word_q; // command word to sys
	logic ev_tog_q; // command event toggle

	assign lrst = SYS_RST_I | CS_N_I;
	assign bit_in = {sh_q[22:0], SI_I};
	assign cur_op = (cnt_q < LEN_CMD) ? bit_in[7:0] : cmd_q;
	assign cur_len = ev_len(cur_op);
	assign fire_l = (cnt_q >= LEN_CMD - 6'h01) && (cur_len != 6'h00)
		&& (cnt_q == cur_len - 6'h01);
	assign load_get = (cnt_q == LOAD_GET) && (cmd_q == OPC_GET);
	assign load_rd = (cnt_q == LOAD_RD) && (cmd_q == OPC_RD_CACHE);
	assign reload = in_data_q && (dph_q == 3'h7);

	// bit counter and input shift, saturating count
	always_ff @(posedge SCK_I or posedge lrst) begin
		if (lrst) begin
			cnt_q <= 6'h00;
			sh_q <= 24'h000000;
		end else begin
			sh_q <= bit_in;
			if (cnt_q != 6'h3F) begin
				cnt_q <= cnt_q + 6'h01;
			end
		end
	end

	// opcode, feature address and column capture
	always_ff @(posedge SCK_I or posedge lrst) begin
		if (lrst) begin
			cmd_q <= 8'h00;
			fa_q <= 8'h00;
			col_q <= 12'h000;
		end else begin
			if (cnt_q == LEN_CMD - 6'h01) begin
				cmd_q <= bit_in[7:0];
			end
			if (load_get) begin
				fa_q <= bit_in[7:0];
			end
			if (cnt_q == LOAD_COL) begin
				col_q <= bit_in[11:0];
			end else if ((load_rd || reload) &&
				(cmd_q == OPC_RD_CACHE)) begin
				col_q <= col_q + 12'h001; // next cache byte
			end
		end
	end

	// output byte load and shift, repeats feature byte
	always_ff @(posedge SCK_I or posedge lrst) begin
		if (lrst) begin
			out_sh_q <= 8'h00;
			dph_q <= 3'h0;
			in_data_q <= 1'b0;
		end else begin
			if (load_get) begin
				out_sh_q <= feat(bit_in[7:0], view_s2_q);
				in_data_q <= 1'b1;
				dph_q <= 3'h0;
			end else if (load_rd ||
				(reload && cmd_q == OPC_RD_CACHE)) begin
				// erased cache except the bad marker
				out_sh_q <= (col_q == SPARE_COL && view_s2_q.bad)
					? BAD_MARK : BLANK_BYTE;
				in_data_q <= 1'b1;
				dph_q <= 3'h0;
			end else if (reload) begin
				out_sh_q <= feat(fa_q, view_s2_q);
				dph_q <= 3'h0;
			end else if (in_data_q) begin
				out_sh_q <= {out_sh_q[6:0], 1'b0};
				dph_q <= dph_q + 3'h1;
			end
		end
	end

	// serial out changes on falling edge, host samples rising
	always_ff @(negedge SCK_I or posedge lrst) begin
		if (lrst) begin
			SO_O <= 1'b0;
			SO_OE_O <= 1'b0;
		end else begin
			SO_O <= out_sh_q[7];
			SO_OE_O <= in_data_q;
		end
	end

	// command word and toggle survive across frames
	always_ff @(posedge SCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			ev_word_q <= '0;
			ev_tog_q <= 1'b0;
		end else if (fire_l) begin
			ev_word_q.op <= cur_op;
			ev_word_q.arg <= (cur_len == LEN_ROW) ? bit_in :
				(cur_len == LEN_SET) ? {8'h00, bit_in[15:0]} :
				24'h000000;
			ev_tog_q <= ~ev_tog_q;
		end
	end

	// status view into link domain, quasi-static bytes
	always_ff @(posedge SCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			view_s1_q <= '0;
			view_s2_q <= '0;
		end else begin
			view_s1_q <= {STATUS_O, OTP_REG_O, cache_bad_q};
			view_s2_q <= view_s1_q;
		end
	end

	// ==========================================================
	// system domain: command receive
	logic [2:0] tog_s_q; // toggle sync chain
	logic tog_seen_q; // last accepted toggle
	logic ev_fire; // one-cycle command event
	snsol_op_t op_q; // running operation
	logic [11:0] timer_q; // busy cycles left
	logic [16:0] row_q; // row of running op
	logic acc; // command accepted now
	logic [7:0] eop; // opcode of event
	logic start_prog; // program execute starts
	logic start_read; // page read starts
	logic start_erase; // block erase starts
	logic start_misc; // reset or lock starts
	logic done; // running op ends now
	logic is_reset; // reset command taken
	logic set_otp; // set-features to otp byte
	logic wel_q; // write enable latch
	logic pfail_q; // program fail flag
	logic efail_q; // erase fail flag
	logic [1:0] ecc_q; // ecc result code
	logic otp_en_q; // otp access enable
	logic otp_protect_bit_q; // volatile protect request
	logic ecc_en_q; // internal ecc enable
	logic otp_lock_q; // permanent otp lock
	logic strap_done_q; // strap already taken
	logic [3:0] next_pg_q; // next otp page in order
	logic otp_prog_bad; // otp program rejected
	logic lock_req; // execute performs otp lock

	// toggle chain, change taken when stages two and three agree
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			tog_s_q <= 3'h0;
			tog_seen_q <= 1'b0;
		end else begin
			tog_s_q <= {tog_s_q[1:0], ev_tog_q};
			if (tog_s_q[1] == tog_s_q[2]) begin
				tog_seen_q <= tog_s_q[2];
			end
		end
	end

	assign ev_fire = (tog_s_q[1] == tog_s_q[2]) &&
		(tog_s_q[2] != tog_seen_q);
	assign eop = ev_word_q.op;
	assign acc = ev_fire && (op_q == OP_IDLE || eop == OPC_RESET);
	assign is_reset = acc && eop == OPC_RESET;
	assign start_prog = acc && eop == OPC_PROG_EXEC && wel_q;
	assign start_erase = acc && eop == OPC_ERASE && wel_q;
	assign start_read = acc && eop == OPC_PAGE_READ;
	assign start_misc = is_reset || (acc && (eop == OPC_GLOCK ||
		eop == OPC_GUNLOCK || eop == OPC_BLOCK || eop == OPC_BUNLOCK));
	assign done = (op_q != OP_IDLE) && (timer_q == 12'h000);
	assign set_otp = acc && eop == OPC_SET &&
		ev_word_q.arg[15:8] == FA_OTP;
	// protect request with enable and no lock yet means lock
	assign lock_req = otp_en_q && otp_protect_bit_q && !otp_lock_q;
	// locked, out of range or out of order otp page
	assign otp_prog_bad = otp_lock_q || (!otp_protect_bit_q &&
		(row_q >= {13'h0000, OTP_PAGES} ||
		{1'b0, row_q[2:0]} != next_pg_q));

	// ==========================================================
	// operation sequencer and busy timer
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			op_q <= OP_IDLE;
			timer_q <= 12'h000;
			row_q <= 17'h00000;
		end else begin
			case (op_q)
				OP_IDLE: begin
					if (start_prog) op_q <= OP_PROG;
					else if (start_read) op_q <= OP_READ;
					else if (start_erase) op_q <= OP_ERASE;
					else if (start_misc) op_q <= OP_MISC;
				end
				OP_PROG, OP_READ, OP_ERASE, OP_MISC: begin
					if (is_reset) op_q <= OP_MISC; // abort
					else if (done) op_q <= OP_IDLE;
				end
				default: op_q <= OP_IDLE;
			endcase
			if (is_reset) begin
				timer_q <= 12'(RST_CYCLES - 1);
			end else if (start_prog || start_read || start_erase ||
				start_misc) begin
				timer_q <= 12'(OP_CYCLES - 1);
				row_q <= ev_word_q.arg[16:0];
			end else if (timer_q != 12'h000) begin
				timer_q <= timer_q - 12'h001;
			end
		end
	end

	// write enable latch, dropped when a write op completes
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			wel_q <= 1'b0;
		end else if (acc && eop == OPC_WR_EN) begin
			wel_q <= 1'b1;
		end else if ((acc && eop == OPC_WR_DIS) || is_reset) begin
			wel_q <= 1'b0;
		end else if (done && (op_q == OP_PROG || op_q == OP_ERASE)) begin
			wel_q <= 1'b0;
		end
	end

	// program fail flag
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			pfail_q <= 1'b0;
		end else if (start_prog || is_reset) begin
			pfail_q <= 1'b0;
		end else if (done && op_q == OP_PROG) begin
			// otp target checked against lock and page order
			pfail_q <= otp_en_q ? (!lock_req && otp_prog_bad)
				: (ARR_FAIL_I || ARR_LOCKED_I);
		end
	end

	// erase fail flag
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			efail_q <= 1'b0;
		end else if (start_erase || is_reset) begin
			efail_q <= 1'b0;
		end else if (done && op_q == OP_ERASE) begin
			efail_q <= ARR_FAIL_I || ARR_LOCKED_I;
		end
	end

	// ecc result code and bad block cache marker
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			ecc_q <= ECC_NONE;
			cache_bad_q <= 1'b0;
		end else if (start_read || is_reset) begin
			ecc_q <= ECC_NONE;
		end else if (done && op_q == OP_READ) begin
			// code passed as given, no errors code when ecc disabled
			ecc_q <= ecc_en_q ? ARR_ECC_I : ECC_NONE;
			cache_bad_q <= ARR_BAD_BLK_I && !otp_en_q &&
				row_q[5:0] == 6'h00;
		end
	end

	// otp feature byte bits, volatile part
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			otp_en_q <= FEAT_RST[OTP_EN_BIT];
			otp_protect_bit_q <= FEAT_RST[OTP_PROTECT_BIT_BIT];
			ecc_en_q <= FEAT_RST[ECC_EN_BIT];
		end else if (set_otp) begin
			otp_en_q <= ev_word_q.arg[OTP_EN_BIT];
			otp_protect_bit_q <= ev_word_q.arg[OTP_PROTECT_BIT_BIT];
			ecc_en_q <= ev_word_q.arg[ECC_EN_BIT];
		end
	end

	// permanent lock, stored state caught after reset release
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			otp_lock_q <= 1'b0;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			otp_lock_q <= OTP_LOCK_STRAP_I;
		end else if (done && op_q == OP_PROG && lock_req) begin
			otp_lock_q <= 1'b1;
		end
	end

	// next otp page, pages accepted in order only
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			next_pg_q <= 4'h0;
		end else if (done && op_q == OP_PROG && otp_en_q &&
			!otp_prog_bad && !ARR_FAIL_I) begin
			next_pg_q <= next_pg_q + 4'h1;
		end
	end

	// registered copies of both feature bytes
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			STATUS_O <= 8'h00;
			OTP_REG_O <= FEAT_RST;
		end else begin
			STATUS_O <= {2'h0, ecc_q, pfail_q, efail_q, wel_q,
				op_q != OP_IDLE};
			OTP_REG_O <= {otp_protect_bit_q || otp_lock_q, otp_en_q, 1'b0,
				ecc_en_q, 4'h0};
		end
	end
endmodule : snsol_top
`default_nettype wire

// ---- logic/snsol_pkg.sv ----
// shared constants and carriers for the status and otp block
package snsol_pkg;
	// ==========================================================
	// command opcodes
	localparam logic [7:0] OPC_WR_EN = 8'h06; // sets write latch
	localparam logic [7:0] OPC_WR_DIS = 8'h04; // clears write latch
	localparam logic [7:0] OPC_GET = 8'h0F; // get features
	localparam logic [7:0] OPC_SET = 8'h1F; // set features
	localparam logic [7:0] OPC_PROG_EXEC = 8'h10; // program execute
	localparam logic [7:0] OPC_PAGE_READ = 8'h13; // page read
	localparam logic [7:0] OPC_ERASE = 8'hD8; // block erase
	localparam logic [7:0] OPC_RESET = 8'hFF; // reset
	localparam logic [7:0] OPC_GLOCK = 8'h7E; // global lock
	localparam logic [7:0] OPC_GUNLOCK = 8'h98; // global unlock
	localparam logic [7:0] OPC_BLOCK = 8'h36; // block lock
	localparam logic [7:0] OPC_BUNLOCK = 8'h39; // block unlock
	localparam logic [7:0] OPC_RD_CACHE = 8'h03; // read from cache
	// ==========================================================
	// feature addresses and field positions
	localparam logic [7:0] FA_OTP = 8'hB0; // otp feature control
	localparam logic [7:0] FA_STATUS = 8'hC0; // operation status
	localparam int ST_ECC_HI = 5; // ecc result code msb
	localparam int ST_ECC_LO = 4; // ecc result code lsb
	localparam int ST_PFAIL = 3; // program fail
	localparam int ST_EFAIL = 2; // erase fail
	localparam int ST_WEL = 1; // write enable latch
	localparam int ST_OIP = 0; // operation in progress
	localparam int OTP_PROTECT_BIT_BIT = 7; // otp protect bit
	localparam int OTP_EN_BIT = 6; // otp access enable
	localparam int ECC_EN_BIT = 4; // internal ecc enable
	// ==========================================================
	// codes, sizes and reset values
	localparam logic [1:0] ECC_NONE = 2'h0; // no errors
	localparam logic [1:0] ECC_FIX_1_7 = 2'h1; // 1 to 7 corrected
	localparam logic [1:0] ECC_UNCORR = 2'h2; // not corrected
	localparam logic [1:0] ECC_FIX_8 = 2'h3; // 8 corrected
	localparam logic [3:0] OTP_PAGES = 4'h8; // otp pages 00h..07h
	localparam int OTP_PAGE_BYTES = 2176; // bytes per otp page
	localparam logic [11:0] SPARE_COL = 12'h800; // byte 2048
	localparam logic [7:0] BLANK_BYTE = 8'hFF; // erased data
	localparam logic [7:0] BAD_MARK = 8'h00; // factory bad marker
	localparam logic [7:0] FEAT_RST = 8'h00; // feature reset value
	// ==========================================================
	// frame bit counts and timing
	localparam logic [5:0] LEN_CMD = 6'h08; // opcode only
	localparam logic [5:0] LEN_SET = 6'h18; // opcode, addr, data
	localparam logic [5:0] LEN_ROW = 6'h20; // opcode, 24b address
	localparam logic [5:0] LOAD_GET = 6'h0F; // edge before get data
	localparam logic [5:0] LOAD_COL = 6'h17; // edge ending column
	localparam logic [5:0] LOAD_RD = 6'h1F; // edge before cache data
	localparam int CLK_PERIOD_NS = 100; // system clock period
	localparam int OP_TIME_NS = 2000; // array operation busy time
	localparam int RST_TIME_NS = 500; // reset busy time
	localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS; // least time, rounded up
	localparam int RST_CYCLES = (RST_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS; // least time, rounded up
	// ==========================================================
	// carriers
	typedef struct packed {
		logic [7:0] op; // opcode
		logic [23:0] arg; // address and data
	} snsol_cmd_t;
	typedef struct packed {
		logic [7:0] status; // status byte
		logic [7:0] otp; // otp feature byte
		logic bad; // cached page is factory bad
	} snsol_view_t;
	typedef enum logic [2:0] {
		OP_IDLE, OP_PROG, OP_READ, OP_ERASE, OP_MISC
	} snsol_op_t;
endpackage : snsol_pkg

// ---- testbench/snsol_properties.sv ----
// concurrent checks on the status and otp block ports
`timescale 1ns/1ps
`default_nettype none
module snsol_properties (
	input wire logic SYS_CLK_I, // system clock
	input wire logic SYS_RST_I, // async reset, high
	input wire logic CS_N_I, // chip select, low
	input wire logic SO_O, // serial data out
	input wire logic SO_OE_O, // serial out enable
	input wire logic [7:0] STATUS_O, // status byte
	input wire logic [7:0] OTP_REG_O // otp feature byte
);
	import snsol_pkg::*;
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (SYS_RST_I);
	// ==========================================================
	// cycles since the link was last selected
	logic [3:0] idle_q; // saturates, so old frames stop counting
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			idle_q <= 4'h0;
		end else if (!CS_N_I) begin
			idle_q <= 4'h0;
		end else if (idle_q != 4'hF) begin
			idle_q <= idle_q + 4'h1;
		end
	end
	// ==========================================================
	// assertions
	status_spare_a: assert property (STATUS_O[7:6] == 2'h0)
		else $error("status spare bits set");
	otp_spare_a: assert property (OTP_REG_O[5] == 1'b0
		&& OTP_REG_O[3:0] == 4'h0)
		else $error("otp spare bits set");
	reset_value_a: assert property ($past(SYS_RST_I)
		|-> STATUS_O == 8'h00 && OTP_REG_O == 8'h00)
		else $error("bytes not clear after reset");
	otp_quiet_a: assert property ($changed(OTP_REG_O)
		|-> idle_q < 4'hC)
		else $error("otp byte changed without a frame");
	link_idle_a: assert property (CS_N_I && $past(CS_N_I)
		|-> !SO_OE_O && !SO_O)
		else $error("serial out driven while deselected");
	busy_min_a: assert property ($rose(STATUS_O[ST_OIP])
		|-> STATUS_O[ST_OIP] [*5])
		else $error("busy flag too short");
	busy_end_a: assert property ($rose(STATUS_O[ST_OIP])
		|-> ##[1:60] !STATUS_O[ST_OIP])
		else $error("busy flag never dropped");
	latch_idle_a: assert property ($rose(STATUS_O[ST_WEL])
		|-> !$past(STATUS_O[ST_OIP]))
		else $error("write latch set while busy");
	pfail_end_a: assert property ($rose(STATUS_O[ST_PFAIL])
		|-> $past(STATUS_O[ST_OIP]))
		else $error("program fail set outside an operation");
	efail_end_a: assert property ($rose(STATUS_O[ST_EFAIL])
		|-> $past(STATUS_O[ST_OIP]))
		else $error("erase fail set outside an operation");
	ecc_end_a: assert property ($changed(STATUS_O[5:4])
		&& STATUS_O[5:4] != 2'h0 |-> $past(STATUS_O[ST_OIP]))
		else $error("ecc code set outside a read");
	pfail_clear_a: assert property ($fell(STATUS_O[ST_PFAIL])
		|-> ##[0:8] STATUS_O[ST_OIP])
		else $error("program fail cleared without an operation");
endmodule : snsol_properties
bind snsol_top snsol_properties i_snsol_properties (
	.SYS_CLK_I(SYS_CLK_I),
	.SYS_RST_I(SYS_RST_I),
	.CS_N_I(CS_N_I),
	.SO_O(SO_O),
	.SO_OE_O(SO_OE_O),
	.STATUS_O(STATUS_O),
	.OTP_REG_O(OTP_REG_O)
);
`default_nettype wire

// ---- testbench/snsol_host.sv ----
// host side model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module snsol_host (
	output logic sck_o, // link clock, still outside frames
	output logic cs_n_o, // chip select, low
	output logic si_o, // serial data to the device
	input wire logic so_i // serial data from the device
);
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end
	// ==========================================================
	// one mode 0 frame, msb first, 32 ns link period
	task automatic xfer(input logic [39:0] tx, input int n,
		output logic [7:0] rx);
		int i;
		rx = 8'h00;
		#7 cs_n_o = 1'b0;
		for (i = 0; i < n; i++) begin
			si_o = tx[39 - i];
			#16 sck_o = 1'b1;
			rx = {rx[6:0], so_i};
			#16 sck_o = 1'b0;
		end
		#16 cs_n_o = 1'b1;
		si_o = ~si_o; // released line shows no stale level
	endtask : xfer
endmodule : snsol_host
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the status and otp block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import snsol_pkg::*;
	// ==========================================================
	// signals and model state
	logic clk = 1'b0; // system clock
	logic rst = 1'b1; // system reset
	logic fail, lck, bad, strap; // array feedback
	logic [1:0] ecc; // array ecc result
	wire sck, cs_n, si; // link from host
	logic so, so_oe; // link from device
	logic [7:0] st, otp, rx; // observed bytes
	integer errors = 0;
	integer compares = 0;
	integer seed = 72;
	int write_enable_latch, pf, ef, ec, een, oen, prt, lkd, pg, badc, i; // model
	logic [7:0] lk [4] = '{OPC_GLOCK, OPC_GUNLOCK, OPC_BLOCK, OPC_BUNLOCK};
	logic [15:0] ot [6] = '{16'h4000, 16'h4002, 16'h4001, 16'h0003,
		16'hC000, 16'h4002}; // otp byte and row per step
	always #(CLK_PERIOD_NS / 2) clk = ~clk;
	snsol_host i_snsol_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si),
		.so_i(so_oe ? so : ~so));
	snsol_top i_snsol_top (.SYS_CLK_I(clk), .SYS_RST_I(rst),
		.SCK_I(sck), .CS_N_I(cs_n), .SI_I(si), .SO_O(so),
		.SO_OE_O(so_oe), .ARR_FAIL_I(fail), .ARR_LOCKED_I(lck),
		.ARR_ECC_I(ecc), .ARR_BAD_BLK_I(bad),
		.OTP_LOCK_STRAP_I(strap), .STATUS_O(st), .OTP_REG_O(otp));
	// ==========================================================
	// model bytes, compare and bus tasks
	function automatic logic [7:0] mst();
		return {2'h0, 2'(ec), pf[0], ef[0], write_enable_latch[0], 1'b0};
	endfunction : mst
	function automatic logic [7:0] mot();
		return {prt[0] | lkd[0], oen[0], 1'b0, een[0], 4'h0};
	endfunction : mot
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic setin(input logic f, l, input logic [1:0] e,
		input logic b);
		@(posedge clk);
		{fail, lck, ecc, bad} <= {f, l, e, b};
		@(negedge clk); // model reads settled levels only
	endtask : setin
	task automatic wen();
		i_snsol_host.xfer({OPC_WR_EN, 32'h0}, 8, rx);
		cyc(10);
		write_enable_latch = 1;
	endtask : wen
	task automatic setf(input logic [7:0] v);
		i_snsol_host.xfer({OPC_SET, FA_OTP, v, 16'h0}, 24, rx);
		cyc(10);
		prt = v[OTP_PROTECT_BIT_BIT];
		oen = v[OTP_EN_BIT];
		een = v[ECC_EN_BIT];
	endtask : setf
	// frame, then measure how long the busy flag stands
	task automatic op(input logic [7:0] c, input logic [23:0] a,
		input int n, input int want);
		int k;
		i_snsol_host.xfer({c, a, 8'h00}, n, rx);
		@(negedge clk);
		for (k = 0; k < 12 && st[ST_OIP] !== 1'b1; k++) @(negedge clk);
		for (k = 0; k < 60 && st[ST_OIP] === 1'b1; k++) @(negedge clk);
		check("busy cycles", 8'(k), 8'(want));
		cyc(10);
	endtask : op
	task automatic prog(input logic [23:0] row);
		if (write_enable_latch) begin
			pf = 0;
			if (!oen) pf = fail | lck;
			else if (lkd) pf = 1;
			else if (prt) lkd = 1;
			else pf = (row != pg);
			if (oen && !pf && !prt) pg++;
		end
		op(OPC_PROG_EXEC, row, 32, write_enable_latch ? OP_CYCLES : 0);
		write_enable_latch = 0;
	endtask : prog
	task automatic erase(input logic [23:0] row);
		if (write_enable_latch) ef = fail | lck;
		op(OPC_ERASE, row, 32, write_enable_latch ? OP_CYCLES : 0);
		write_enable_latch = 0;
	endtask : erase
	task automatic pread(input logic [23:0] row);
		ec = een ? ecc : 0;
		badc = bad && !oen && row[5:0] == 6'h00;
		op(OPC_PAGE_READ, row, 32, OP_CYCLES);
	endtask : pread
	task automatic both();
		i_snsol_host.xfer({OPC_GET, FA_STATUS, 16'h0, 8'h0}, 24, rx);
		cyc(10);
		check("link status", rx, mst());
		check("status out", st, mst());
		check("otp out", otp, mot());
	endtask : both
	task automatic results();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results
	// ==========================================================
	// watchdog
	initial begin
		#(20000 * CLK_PERIOD_NS);
		errors++;
		results();
	end
	// ==========================================================
	// main sequence
	initial begin
		{fail, lck, bad, strap, ecc} = 6'h00;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		cyc(3);
		both();
		wen();
		both();
		i_snsol_host.xfer({OPC_WR_DIS, 32'h0}, 8, rx);
		cyc(10);
		write_enable_latch = 0;
		both();
		prog(24'h5);
		erase(24'h40);
		both();
		for (i = 0; i < 4; i++) begin
			setin(i == 0, i == 2, 2'h0, 1'b0);
			wen();
			if (i < 2) prog(24'h5);
			else erase(24'h40);
			both();
		end
		setf(8'h10);
		for (i = 0; i < 6; i++) begin
			setin(1'b0, 1'b0, (i < 4) ? 2'(i) : 2'($random(seed)), 1'b0);
			pread(24'h7);
			both();
		end
		setin(1'b1, 1'b1, 2'h3, 1'b0);
		wen();
		prog(24'h8);
		wen();
		erase(24'h40);
		wen();
		op(OPC_RESET, 24'h0, 8, RST_CYCLES);
		write_enable_latch = 0;
		pf = 0;
		ef = 0;
		ec = 0;
		both();
		for (i = 0; i < 4; i++) begin
			op(lk[i], 24'h0, (i < 2) ? 8 : 32, OP_CYCLES);
			both();
		end
		setf(8'h00);
		for (i = 0; i < 4; i++) begin
			setin(1'b0, 1'b0, 2'h2, i < 2);
			pread(24'h40);
			i_snsol_host.xfer({OPC_RD_CACHE,
				i[0] ? 16'h0 : {4'h0, SPARE_COL}, 16'h0}, 40, rx);
			cyc(10);
			check("cache byte", rx, (!i[0] && badc) ? BAD_MARK
				: BLANK_BYTE);
		end
		both();
		for (i = 0; i < 6; i++) begin
			setf(ot[i][15:8]);
			wen();
			prog({16'h0, ot[i][7:0]});
			both();
		end
		setf(8'h00);
		both();
		@(posedge clk);
		strap <= 1'b1;
		rst <= 1'b1;
		cyc(3);
		@(posedge clk);
		rst <= 1'b0;
		{write_enable_latch, pf, ef, ec, een, oen, prt, pg, badc} = '0;
		lkd = 1;
		cyc(3);
		both();
		setf(8'h40);
		wen();
		prog(24'h0);
		both();
		results();
	end
endmodule : tb
`default_nettype wire
